// ### hw/hps_pin_sharing.sv
// Pin multiplexer for the shared host-port / PCI / serial PROM pin group
// How it works
// - Width strap low: host port 16 bits, upper sixteen data pins undriven.
// - Width strap high: host port uses all 32 data pins.
// - PCI strap high: data pins carry PCI address/data instead.
// - Command/byte lane 0 pin is PCI bidirectional, else tied off.
// - PROM chip select driven in PCI mode, else tied off.
// - PROM clock pin idle by default, PCI mode drives serial clock.
// - PCI mode takes serial data in from the PROM data output.
// - PCI mode drives serial data out to PROM input; idle otherwise.
// - Shared pin 15 is GPIO or PCI reset input.
// - Shared pin 14 is GPIO or PCI clock input.
// - Shared pin 13 is GPIO or tristatable PCI interrupt A output.
// - Shared pin 12 is GPIO or PCI grant input.
// - Shared pin 11 is GPIO or tristatable PCI request output.
// - Shared pin 10 is GPIO or PCI command/byte lane 3.
// - Shared pin 9 is GPIO or PCI device select input.
`timescale 1ns/100ps
`default_nettype none

module hps_pin_sharing
  import hps_pkg::*;
#(
  parameter int DATA_W = HPS_DATA_W
) (
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  // Straps
  input  wire logic              width_strap_pin,
  input  wire logic              pci_enable_strap,
  // Shared data pins
  input  wire logic [DATA_W-1:0] hd_in,
  output var  logic [DATA_W-1:0] hd_out,
  output var  logic [DATA_W-1:0] hd_oe,
  // Host-port core side
  input  wire logic [DATA_W-1:0] host_port_dout,
  input  wire logic [DATA_W-1:0] host_port_doe,
  output var  logic [DATA_W-1:0] host_port_din,
  output var  logic              host_port_narrow_mode,
  output var  logic              host_port_wide_mode,
  // PCI core side
  input  wire logic [DATA_W-1:0] pci_ad_dout,
  input  wire logic [DATA_W-1:0] pci_ad_doe,
  output var  logic [DATA_W-1:0] pci_ad_din,
  output var  logic              pci_mode,
  // Command/byte lane 0 pin
  input  wire logic              cbe0_pin_in,
  output var  logic              cbe0_pin_out,
  output var  logic              cbe0_pin_oe,
  input  wire logic              pci_cmd_byte_lane0_dout,
  input  wire logic              pci_cmd_byte_lane0_doe,
  output var  logic              pci_cmd_byte_lane0_din,
  // Serial PROM pins
  output var  logic              prom_chip_select,
  output var  logic              prom_chip_select_oe,
  output var  logic              prom_serial_clock,
  output var  logic              prom_serial_clock_oe,
  input  wire logic              prom_serial_in,
  output var  logic              prom_serial_out,
  output var  logic              prom_serial_out_oe,
  input  wire logic              prom_cs_core,
  input  wire logic              prom_clk_core,
  input  wire logic              prom_dout_core,
  output var  logic              prom_din_core,
  // Shared general-purpose pins 0..15
  input  wire logic [15:0]       shared_io_in,
  output var  logic [15:0]       shared_io_out,
  output var  logic [15:0]       shared_io_oe,
  input  wire logic [15:0]       gpio_dout,
  input  wire logic [15:0]       gpio_doe,
  output var  logic [15:0]       gpio_din,
  // PCI control signals, core side
  output var  logic              pci_reset_in,
  output var  logic              pci_clock_in,
  input  wire logic              pci_interrupt_a_out,
  input  wire logic              pci_interrupt_a_oe,
  output var  logic              pci_grant_in,
  input  wire logic              pci_request_out,
  input  wire logic              pci_request_oe,
  input  wire logic              pci_cmd_byte_lane3_dout,
  input  wire logic              pci_cmd_byte_lane3_doe,
  output var  logic              pci_cmd_byte_lane3_din,
  output var  logic              pci_device_select_in
);

  // ===========================================================
  // Strap capture
  logic      armed;
  logic      next_armed;
  hps_mode_t mode;
  hps_mode_t next_mode;
  logic      pci;
  logic      wide;

  always_comb begin
    next_armed = 1'b1;
    next_mode  = mode;
    if (!armed) begin
      if (pci_enable_strap)
        next_mode = HPS_MODE_PCI;
      else if (width_strap_pin)
        next_mode = HPS_MODE_WIDE;
      else
        next_mode = HPS_MODE_NARROW;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      armed <= 1'b0;
      mode  <= HPS_MODE_NARROW;
    end else begin
      armed <= next_armed;
      mode  <= next_mode;
    end
  end

  assign pci  = armed && (mode == HPS_MODE_PCI);
  assign wide = armed && (mode == HPS_MODE_WIDE);

  // ===========================================================
  // Pin selection (all outputs registered)
  logic [DATA_W-1:0] next_hd_out, next_hd_oe, next_host_din, next_ad_din;
  logic [15:0]       next_io_out, next_io_oe, next_gpio_din;
  logic [15:0]       gp_sel;
  logic              next_cbe0_out, next_cbe0_oe, next_cbe0_din;
  logic              next_cs, next_cs_oe, next_sclk, next_sclk_oe;
  logic              next_sdo, next_sdo_oe, next_sdi;
  logic              next_pci_reset_in, next_pclk, next_pci_grant_in, next_cbe3_din;
  logic              next_idsel, next_narrow, next_wide, next_pci;

  // PCI-owned bits of the general-purpose group
  assign gp_sel = pci ? 16'hfe00 : 16'h0000;

  always_comb begin
    next_pci      = pci;
    next_wide     = wide;
    next_narrow   = armed && (mode == HPS_MODE_NARROW);
    next_hd_out   = host_port_dout;
    next_hd_oe    = host_port_doe;
    next_host_din = hd_in;
    next_ad_din   = '0;
    if (pci) begin
      next_hd_out   = pci_ad_dout;
      next_hd_oe    = pci_ad_doe;
      next_ad_din   = hd_in;
      next_host_din = '0;
    end else if (!wide) begin
      next_hd_oe[DATA_W-1:HPS_NARROW_W]    = '0;
      next_hd_out[DATA_W-1:HPS_NARROW_W]   = '0;
      next_host_din[DATA_W-1:HPS_NARROW_W] = '0;
    end
    if (!armed) begin
      next_hd_oe = '0;
    end
    next_cbe0_out = pci ? pci_cmd_byte_lane0_dout : HPS_TIE_OFF;
    next_cbe0_oe  = pci && pci_cmd_byte_lane0_doe;
    next_cbe0_din = pci ? cbe0_pin_in : HPS_TIE_OFF;
    next_cs       = pci ? prom_cs_core : HPS_TIE_OFF;
    next_cs_oe    = pci;
    next_sclk     = pci ? prom_clk_core : HPS_TIE_OFF;
    next_sclk_oe  = pci;
    next_sdi      = pci ? prom_serial_in : HPS_TIE_OFF;
    next_sdo      = pci ? prom_dout_core : HPS_TIE_OFF;
    next_sdo_oe   = pci;
    next_io_out   = gpio_dout & ~gp_sel;
    next_io_oe    = gpio_doe & ~gp_sel;
    next_gpio_din = shared_io_in & ~gp_sel;
    next_pci_reset_in     = pci && shared_io_in[HPS_IO_RST];
    next_pclk     = pci && shared_io_in[HPS_IO_CLK];
    next_io_out[HPS_IO_INTA] = pci ? pci_interrupt_a_out
                                   : gpio_dout[HPS_IO_INTA];
    next_io_oe[HPS_IO_INTA]  = pci ? pci_interrupt_a_oe
                                   : gpio_doe[HPS_IO_INTA];
    next_pci_grant_in     = pci && shared_io_in[HPS_IO_GNT];
    next_io_out[HPS_IO_REQ]  = pci ? pci_request_out
                                   : gpio_dout[HPS_IO_REQ];
    next_io_oe[HPS_IO_REQ]   = pci ? pci_request_oe
                                   : gpio_doe[HPS_IO_REQ];
    next_io_out[HPS_IO_CBE3] = pci ? pci_cmd_byte_lane3_dout
                                   : gpio_dout[HPS_IO_CBE3];
    next_io_oe[HPS_IO_CBE3]  = pci ? pci_cmd_byte_lane3_doe
                                   : gpio_doe[HPS_IO_CBE3];
    next_cbe3_din = pci && shared_io_in[HPS_IO_CBE3];
    next_idsel    = pci && shared_io_in[HPS_IO_IDSEL];
    if (!armed) begin
      next_io_oe = '0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hd_out                 <= '0;
      hd_oe                  <= '0;
      host_port_din          <= '0;
      pci_ad_din             <= '0;
      host_port_narrow_mode  <= 1'b0;
      host_port_wide_mode    <= 1'b0;
      pci_mode               <= 1'b0;
      cbe0_pin_out           <= 1'b0;
      cbe0_pin_oe            <= 1'b0;
      pci_cmd_byte_lane0_din <= 1'b0;
      prom_chip_select       <= 1'b0;
      prom_chip_select_oe    <= 1'b0;
      prom_serial_clock      <= 1'b0;
      prom_serial_clock_oe   <= 1'b0;
      prom_serial_out        <= 1'b0;
      prom_serial_out_oe     <= 1'b0;
      prom_din_core          <= 1'b0;
      shared_io_out          <= '0;
      shared_io_oe           <= '0;
      gpio_din               <= '0;
      pci_reset_in           <= 1'b0;
      pci_clock_in           <= 1'b0;
      pci_grant_in           <= 1'b0;
      pci_cmd_byte_lane3_din <= 1'b0;
      pci_device_select_in   <= 1'b0;
    end else begin
      hd_out                 <= next_hd_out;
      hd_oe                  <= next_hd_oe;
      host_port_din          <= next_host_din;
      pci_ad_din             <= next_ad_din;
      host_port_narrow_mode  <= next_narrow;
      host_port_wide_mode    <= next_wide;
      pci_mode               <= next_pci;
      cbe0_pin_out           <= next_cbe0_out;
      cbe0_pin_oe            <= next_cbe0_oe;
      pci_cmd_byte_lane0_din <= next_cbe0_din;
      prom_chip_select       <= next_cs;
      prom_chip_select_oe    <= next_cs_oe;
      prom_serial_clock      <= next_sclk;
      prom_serial_clock_oe   <= next_sclk_oe;
      prom_serial_out        <= next_sdo;
      prom_serial_out_oe     <= next_sdo_oe;
      prom_din_core          <= next_sdi;
      shared_io_out          <= next_io_out;
      shared_io_oe           <= next_io_oe;
      gpio_din               <= next_gpio_din;
      pci_reset_in           <= next_pci_reset_in;
      pci_clock_in           <= next_pclk;
      pci_grant_in           <= next_pci_grant_in;
      pci_cmd_byte_lane3_din <= next_cbe3_din;
      pci_device_select_in   <= next_idsel;
    end
  end

endmodule : hps_pin_sharing

`default_nettype wire

// ### hw/hps_pkg.sv
// Constants and types for the host-port / PCI pin-sharing block
package hps_pkg;

  // ===========================================================
  // Widths and pin positions
  localparam int HPS_DATA_W    = 32;
  localparam int HPS_NARROW_W  = 16;
  localparam int HPS_IO_LO     = 9;
  localparam int HPS_IO_HI     = 15;
  localparam int HPS_IO_W      = 16;
  localparam int HPS_IO_RST    = 15;
  localparam int HPS_IO_CLK    = 14;
  localparam int HPS_IO_INTA   = 13;
  localparam int HPS_IO_GNT    = 12;
  localparam int HPS_IO_REQ    = 11;
  localparam int HPS_IO_CBE3   = 10;
  localparam int HPS_IO_IDSEL  = 9;

  // ===========================================================
  // Reset and tie-off values
  localparam logic HPS_STRAP_RST = 1'b0;
  localparam logic HPS_TIE_OFF   = 1'b0;

  // ===========================================================
  // Pin-group modes
  typedef enum logic [1:0] {
    HPS_MODE_NARROW,
    HPS_MODE_WIDE,
    HPS_MODE_PCI
  } hps_mode_t;

endpackage : hps_pkg

// ### verification/hps_far_side.sv
// Far side model: data bus agent and serial memory
`timescale 1ns/100ps
`default_nettype none
module hps_far_side (
  input  wire logic [31:0] hd_out,
  input  wire logic [31:0] hd_oe,
  input  wire logic [31:0] ext_data,
  output var  logic [31:0] hd_in,
  input  wire logic        cs,
  input  wire logic        cs_oe,
  input  wire logic        sclk,
  input  wire logic        sout,
  input  wire logic        sout_oe,
  output var  logic        sin
);
  // Memory output starts at its pull-up level until the first bit lands
  logic prom_bit = 1'b1;
  // Released pins carry fresh far-side data every cycle
  assign hd_in = (hd_oe & hd_out) | (~hd_oe & ext_data);
  always @(posedge sclk) begin
    if (cs && sout_oe) begin
      prom_bit <= sout;
    end
  end
  // Deselected memory leaves the line to its pull-up
  assign sin = (cs_oe && cs) ? prom_bit : 1'b1;
endmodule : hps_far_side
`default_nettype wire

// ### verification/hps_pin_sharing_sva.sv
// Checker for the shared host-port / PCI pin group
`timescale 1ns/100ps
`default_nettype none
module hps_pin_sharing_sva #(
  parameter int DATA_W = 32
) (
  input wire logic              ref_clk,
  input wire logic              nrst,
  input wire logic              host_port_narrow_mode,
  input wire logic              host_port_wide_mode,
  input wire logic              pci_mode,
  input wire logic [DATA_W-1:0] hd_in,
  input wire logic [DATA_W-1:0] hd_out,
  input wire logic [DATA_W-1:0] hd_oe,
  input wire logic [DATA_W-1:0] host_port_doe,
  input wire logic [DATA_W-1:0] pci_ad_dout,
  input wire logic [DATA_W-1:0] pci_ad_din,
  input wire logic              cbe0_pin_out,
  input wire logic              cbe0_pin_oe,
  input wire logic              prom_chip_select_oe,
  input wire logic              prom_serial_clock,
  input wire logic              prom_serial_clock_oe,
  input wire logic              prom_serial_out_oe,
  input wire logic              prom_clk_core,
  input wire logic              prom_serial_in,
  input wire logic              prom_din_core,
  input wire logic [15:0]       shared_io_oe,
  input wire logic [15:0]       gpio_doe,
  input wire logic              pci_interrupt_a_oe,
  input wire logic              pci_request_oe,
  input wire logic              pci_cmd_byte_lane3_doe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic run;
  assign run = pci_mode | host_port_wide_mode | host_port_narrow_mode;
  logic pp;
  assign pp = pci_mode;
  a_narrow_upper_hiz: assert property (
    host_port_narrow_mode |-> hd_oe[31:16] == 16'h0)
    else $error("upper data pins driven in narrow mode");
  a_wide_all_pins: assert property (
    host_port_wide_mode && $past(run) |-> hd_oe == $past(host_port_doe))
    else $error("wide mode data enables wrong");
  a_pci_ad_map: assert property (
    pp && $past(pp) |-> hd_out == $past(pci_ad_dout)
    && pci_ad_din == $past(hd_in)) else $error("address/data path wrong");
  a_cbe0_tied: assert property (
    !pp |-> !cbe0_pin_oe && !cbe0_pin_out) else $error("lane 0 not tied off");
  a_prom_enable: assert property (
    {prom_chip_select_oe, prom_serial_clock_oe, prom_serial_out_oe} == {3{pp}})
    else $error("serial memory enables wrong");
  a_prom_clk_din: assert property (
    pp && $past(pp) |-> prom_serial_clock == $past(prom_clk_core)
    && prom_din_core == $past(prom_serial_in)) else $error("serial path wrong");
  a_gpio_owns: assert property (
    run && !pp && $past(run) |-> shared_io_oe[15:9] == $past(gpio_doe[15:9]))
    else $error("general pins not owned by gpio");
  a_pci_io_drive: assert property (
    pp && $past(pp) |-> shared_io_oe[15:9] == {2'b00, $past(pci_interrupt_a_oe),
    1'b0, $past(pci_request_oe), $past(pci_cmd_byte_lane3_doe), 1'b0})
    else $error("control pin enables wrong");
  a_mode_fixed: assert property (
    run |=> $stable({pp, host_port_wide_mode, host_port_narrow_mode})
    && $onehot(run ? {pp, host_port_wide_mode, host_port_narrow_mode} : 3'h1))
    else $error("mode changed after latch");
  c_pci: cover property (pp && prom_serial_clock);
  c_wide: cover property (host_port_wide_mode && hd_oe[31]);
  c_narrow: cover property (host_port_narrow_mode && hd_oe[0]);
endmodule : hps_pin_sharing_sva
bind hps_pin_sharing hps_pin_sharing_sva #(.DATA_W(DATA_W)) u_sva (
  .ref_clk, .nrst, .host_port_narrow_mode, .host_port_wide_mode, .pci_mode,
  .hd_in, .hd_out, .hd_oe, .host_port_doe, .pci_ad_dout, .pci_ad_din,
  .cbe0_pin_out, .cbe0_pin_oe, .prom_chip_select_oe, .prom_serial_clock,
  .prom_serial_clock_oe, .prom_serial_out_oe, .prom_clk_core, .prom_serial_in,
  .prom_din_core, .shared_io_oe, .gpio_doe, .pci_interrupt_a_oe,
  .pci_request_oe, .pci_cmd_byte_lane3_doe);
`default_nettype wire

// ### verification/hps_pin_sharing_tb.sv
// Self-checking bench for the shared host-port / PCI pin group
`timescale 1ns/100ps
`default_nettype none
module hps_pin_sharing_tb;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic wstrap = 1'b0;
  logic pstrap = 1'b0;
  logic [191:0] r = '0;
  logic [191:0] s;
  logic [31:0] ext = '0;
  logic [31:0] hd_in, hd_out, hd_oe, ad_din, hin_s, hp_din;
  logic [15:0] io_oe, io_out, sio, sio_s, gp_din;
  logic [4:0] pin_in;
  logic m_p, m_w, m_n, c_out, c_oe, cs, cs_oe, sck, sck_oe, so, so_oe, si, din;
  logic si_s, c_din;
  integer seed = 84394;
  int error_cnt = 0;
  int total_checks = 0;
  always #25 ref_clk = ~ref_clk;
  assign sio = (io_oe & io_out) | (~io_oe & r[143:128]);
  hps_pin_sharing u_hps_pin_sharing (
    .ref_clk, .nrst, .width_strap_pin(wstrap), .pci_enable_strap(pstrap),
    .hd_in, .hd_out, .hd_oe, .host_port_dout(r[31:0]),
    .host_port_doe(r[63:32]), .host_port_din(hp_din),
    .host_port_narrow_mode(m_n),
    .host_port_wide_mode(m_w), .pci_ad_dout(r[95:64]), .pci_ad_doe(r[127:96]),
    .pci_ad_din(ad_din), .pci_mode(m_p), .cbe0_pin_in(r[176]),
    .cbe0_pin_out(c_out), .cbe0_pin_oe(c_oe), .pci_cmd_byte_lane0_dout(r[177]),
    .pci_cmd_byte_lane0_doe(r[178]), .pci_cmd_byte_lane0_din(c_din),
    .prom_chip_select(cs), .prom_chip_select_oe(cs_oe), .prom_serial_clock(sck),
    .prom_serial_clock_oe(sck_oe), .prom_serial_in(si), .prom_serial_out(so),
    .prom_serial_out_oe(so_oe), .prom_cs_core(r[179]), .prom_clk_core(r[180]),
    .prom_dout_core(r[181]), .prom_din_core(din), .shared_io_in(sio),
    .shared_io_out(io_out), .shared_io_oe(io_oe), .gpio_dout(r[159:144]),
    .gpio_doe(r[175:160]), .gpio_din(gp_din), .pci_reset_in(pin_in[4]),
    .pci_clock_in(pin_in[3]), .pci_interrupt_a_out(r[182]),
    .pci_interrupt_a_oe(r[183]), .pci_grant_in(pin_in[2]),
    .pci_request_out(r[184]), .pci_request_oe(r[185]),
    .pci_cmd_byte_lane3_dout(r[186]), .pci_cmd_byte_lane3_doe(r[187]),
    .pci_cmd_byte_lane3_din(pin_in[1]), .pci_device_select_in(pin_in[0]));
  hps_far_side u_hps_far_side (.hd_out, .hd_oe, .ext_data(ext), .hd_in,
    .cs, .cs_oe, .sclk(sck), .sout(so), .sout_oe(so_oe), .sin(si));
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  function automatic logic [31:0] exp_oe(input logic p, input logic w,
                                         input logic [191:0] v);
    if (p) return v[127:96];
    return w ? v[63:32] : {16'h0, v[47:32]};
  endfunction : exp_oe
  task automatic run_mode(input logic w, input logic p);
    nrst = 1'b0;
    wstrap = w;
    pstrap = p;
    repeat (4) @(posedge ref_clk);
    #1 nrst = 1'b1;
    for (int k = 0; k < 40; k++) begin
      @(negedge ref_clk);
      s = r;
      hin_s = hd_in;
      si_s = si;
      sio_s = sio;
      @(posedge ref_clk);
      #1;
      if (k == 0) check("armed_oe", hd_oe, 32'h0);
      if (k >= 2) begin
        check("mode", 32'({m_p, m_w, m_n}), 32'({p, w & !p, !w & !p}));
        check("hd_oe", hd_oe, exp_oe(p, w, s));
        check("ad_din", ad_din, p ? hin_s : 32'h0);
        check("cbe0", 32'({c_oe, c_out, c_din}),
          p ? 32'(s[178:176]) : 32'h0);
        check("hd_out", hd_out, p ? s[95:64] : w ? s[31:0]
          : {16'h0, s[15:0]});
        check("host_din", hp_din, p ? 32'h0 : w ? hin_s
          : {16'h0, hin_s[15:0]});
        check("io_out", 32'(io_out), p ? 32'({2'b00, s[182],
          1'b0, s[184], s[186], 1'b0, s[152:144]})
          : 32'(s[159:144]));
        check("gpio_din", 32'(gp_din),
          p ? 32'(sio_s[8:0]) : 32'(sio_s));
        check("prom", 32'({cs_oe, sck_oe, so_oe, cs, sck, so, din}),
          p ? 32'({3'b111, s[179], s[180], s[181], si_s}) : 32'h0);
        check("io_oe", 32'(io_oe[15:9]), p ? 32'({2'b00, s[183], 1'b0,
          s[185], s[187], 1'b0}) : 32'(s[175:169]));
        check("pci_in", 32'(pin_in), p ? 32'({sio_s[15:14], sio_s[12],
          sio_s[10:9]}) : 32'h0);
      end
      if (k == 5) begin
        wstrap = ~w;
        pstrap = ~p;
      end
      r = {$random(seed), $random(seed), $random(seed), $random(seed),
           $random(seed), $random(seed)};
      ext = $random(seed);
      if (k == 10) r = '1;
      if (k == 11) r = '0;
    end
  endtask : run_mode
  initial begin
    for (int i = 0; i < 4; i++) begin
      run_mode(i[0], i[1]);
    end
    report_and_stop();
  end
endmodule : hps_pin_sharing_tb
`default_nettype wire
